// >>> hw/odl_pkg.sv
package odl_pkg;

  // ----------------------------------------------------------------
  // decoded classes, operations, sizes and addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ODL_CLS_SINGLE,
    ODL_CLS_RESERVED,
    ODL_CLS_SHORT_JUMP,
    ODL_CLS_SHORT_CALL,
    ODL_CLS_BIT_CLEAR,
    ODL_CLS_BIT_SET,
    ODL_CLS_ARITH,
    ODL_CLS_OTHER_PAGE
  } odl_class_t;

  typedef enum logic [4:0] {
    ODL_OP_NONE,
    ODL_OP_SKIP,
    ODL_OP_ZERO,
    ODL_OP_COMPLEMENT,
    ODL_OP_ARITH_INVERT,
    ODL_OP_SWAP,
    ODL_OP_MINUS_ONE,
    ODL_OP_SIGN_WIDEN,
    ODL_OP_PLUS_ONE,
    ODL_OP_LOGICAL_RIGHT,
    ODL_OP_LOGICAL_LEFT,
    ODL_OP_ARITH_RIGHT,
    ODL_OP_NORMALIZE,
    ODL_OP_CONJUNCTION,
    ODL_OP_SUM,
    ODL_OP_DIFFERENCE,
    ODL_OP_UNSIGNED_PRODUCT,
    ODL_OP_JUMP,
    ODL_OP_CALL,
    ODL_OP_TEST_CLEAR,
    ODL_OP_TEST_SET
  } odl_op_t;

  typedef enum logic [1:0] {ODL_SZ_NONE, ODL_SZ_BYTE, ODL_SZ_WORD, ODL_SZ_LONG} odl_size_t;

  typedef enum logic [2:0] {
    ODL_AM_NONE,
    ODL_AM_DIRECT,
    ODL_AM_IMMEDIATE,
    ODL_AM_INDIRECT,
    ODL_AM_INDEXED
  } odl_mode_t;

  typedef struct packed {
    odl_class_t cls;
    odl_op_t op;
    odl_size_t size;
    odl_mode_t mode;
    logic [1:0] operands;
    logic dest_is_src;
    logic [2:0] field;
    logic reserved;
  } odl_dec_t;

  // ----------------------------------------------------------------
  // opcode boundaries of the low page
  // ----------------------------------------------------------------
  localparam logic [7:0] ODL_SINGLE_WORD_BASE = 8'h00;
  localparam logic [7:0] ODL_SINGLE_BYTE_BASE = 8'h10;
  localparam logic [7:0] ODL_SINGLE_BYTE_LAST = 8'h1A;
  localparam logic [7:0] ODL_JUMP_BASE = 8'h20;
  localparam logic [7:0] ODL_CALL_BASE = 8'h28;
  localparam logic [7:0] ODL_TEST_CLEAR_BASE = 8'h30;
  localparam logic [7:0] ODL_TEST_SET_BASE = 8'h38;
  localparam logic [7:0] ODL_THREE_OP_BASE = 8'h40;
  localparam logic [7:0] ODL_TWO_OP_BASE = 8'h60;
  localparam logic [7:0] ODL_PAGE_LAST = 8'h6B;
  localparam logic [7:0] ODL_OPCODE_RESET = 8'h00;

  // reset value of the decoded word: nothing, no operands
  localparam odl_dec_t ODL_DEC_RESET = '{
    cls: ODL_CLS_RESERVED, op: ODL_OP_NONE, size: ODL_SZ_NONE, mode: ODL_AM_NONE,
    operands: 2'h0, dest_is_src: 1'b0, field: 3'h0, reserved: 1'b0
  };

  // inclusive range test used by both decoders
  function automatic logic odl_in_range(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
    odl_in_range = (op >= lo) && (op <= hi);
  endfunction : odl_in_range

endpackage : odl_pkg

// >>> hw/odl_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// one partial decode: a hit flag and the decoded word
// ----------------------------------------------------------------
interface odl_dec_if import odl_pkg::*; ();
  logic hit;
  odl_dec_t dec;
  modport prod (output hit, output dec);
  modport cons (input hit, input dec);
endinterface : odl_dec_if

`default_nettype wire

// >>> hw/odl_single_decode.sv
`timescale 1ns/1ps
`default_nettype none

module odl_single_decode import odl_pkg::*; (
  // opcode byte
  input wire logic [7:0] opcode,
  // partial decode
  odl_dec_if.prod res
);

  // ----------------------------------------------------------------
  // single-operand page, 00 to 1F
  // ----------------------------------------------------------------
  logic is_byte;
  logic in_page;

  assign in_page = odl_in_range(opcode, ODL_SINGLE_WORD_BASE, ODL_JUMP_BASE - 8'h01);
  assign is_byte = opcode[4];

  // low nibble picks the operation; byte half has no long forms
  always_comb begin
    res.hit = in_page;
    res.dec = ODL_DEC_RESET;
    res.dec.cls = ODL_CLS_SINGLE;
    res.dec.operands = 2'h1;
    res.dec.size = is_byte ? ODL_SZ_BYTE : ODL_SZ_WORD;
    unique case (opcode[3:0])
      4'h0: res.dec.op = is_byte ? ODL_OP_NONE : ODL_OP_SKIP;
      4'h1: res.dec.op = ODL_OP_ZERO;
      4'h2: res.dec.op = ODL_OP_COMPLEMENT;
      4'h3: res.dec.op = ODL_OP_ARITH_INVERT;
      4'h4: res.dec.op = ODL_OP_SWAP;
      4'h5: res.dec.op = ODL_OP_MINUS_ONE;
      4'h6: res.dec.op = ODL_OP_SIGN_WIDEN;
      4'h7: res.dec.op = ODL_OP_PLUS_ONE;
      4'h8: res.dec.op = ODL_OP_LOGICAL_RIGHT;
      4'h9: res.dec.op = ODL_OP_LOGICAL_LEFT;
      4'hA: res.dec.op = ODL_OP_ARITH_RIGHT;
      4'hB: res.dec.op = ODL_OP_NONE;
      4'hC: res.dec.op = is_byte ? ODL_OP_NONE : ODL_OP_LOGICAL_RIGHT;
      4'hD: res.dec.op = is_byte ? ODL_OP_NONE : ODL_OP_LOGICAL_LEFT;
      4'hE: res.dec.op = is_byte ? ODL_OP_NONE : ODL_OP_ARITH_RIGHT;
      4'hF: res.dec.op = is_byte ? ODL_OP_NONE : ODL_OP_NORMALIZE;
    endcase
    // long shifts and normalise work on double words
    if (!is_byte && opcode[3:2] == 2'b11) begin
      res.dec.size = ODL_SZ_LONG;
    end
    // 0B, 10 and 1B..1F have no instruction: a quiet no-op
    if (res.dec.op == ODL_OP_NONE) begin
      res.dec.cls = ODL_CLS_RESERVED;
      res.dec.size = ODL_SZ_NONE;
      res.dec.operands = 2'h0;
      res.dec.reserved = 1'b1;
    end
  end

endmodule : odl_single_decode

`default_nettype wire

// >>> hw/odl_group_decode.sv
`timescale 1ns/1ps
`default_nettype none

module odl_group_decode import odl_pkg::*; (
  // opcode byte
  input wire logic [7:0] opcode,
  // partial decode
  odl_dec_if.prod res
);

  // ----------------------------------------------------------------
  // short transfers, bit tests and arithmetic groups, 20 to 6B
  // ----------------------------------------------------------------
  function automatic odl_mode_t odl_mode_of(input logic [1:0] low);
    unique case (low)
      2'd0: odl_mode_of = ODL_AM_DIRECT;
      2'd1: odl_mode_of = ODL_AM_IMMEDIATE;
      2'd2: odl_mode_of = ODL_AM_INDIRECT;
      2'd3: odl_mode_of = ODL_AM_INDEXED;
    endcase
  endfunction : odl_mode_of

  // group of four within a sixteen: and, add, subtract, multiply
  function automatic odl_op_t odl_arith_of(input logic [1:0] grp);
    unique case (grp)
      2'd0: odl_arith_of = ODL_OP_CONJUNCTION;
      2'd1: odl_arith_of = ODL_OP_SUM;
      2'd2: odl_arith_of = ODL_OP_DIFFERENCE;
      2'd3: odl_arith_of = ODL_OP_UNSIGNED_PRODUCT;
    endcase
  endfunction : odl_arith_of

  logic is_arith;
  logic is_three;

  assign res.hit = odl_in_range(opcode, ODL_JUMP_BASE, ODL_PAGE_LAST);
  assign is_arith = odl_in_range(opcode, ODL_THREE_OP_BASE, ODL_PAGE_LAST);
  assign is_three = odl_in_range(opcode, ODL_THREE_OP_BASE, ODL_TWO_OP_BASE - 8'h01);

  // opcode bits [4:3] pick the transfer kind below 40
  always_comb begin
    res.dec = ODL_DEC_RESET;
    res.dec.field = opcode[2:0];
    res.dec.operands = 2'h1;
    if (is_arith) begin
      res.dec.cls = ODL_CLS_ARITH;
      res.dec.op = odl_arith_of(opcode[3:2]);
      res.dec.mode = odl_mode_of(opcode[1:0]);
      res.dec.field = 3'h0;
      res.dec.operands = is_three ? 2'h3 : 2'h2;
      res.dec.dest_is_src = !is_three;
      // only the 50..5F half of the three-operand page is byte wide
      res.dec.size = (is_three && opcode[4]) ? ODL_SZ_BYTE : ODL_SZ_WORD;
    end else if (opcode[4]) begin
      res.dec.cls = opcode[3] ? ODL_CLS_BIT_SET : ODL_CLS_BIT_CLEAR;
      res.dec.op = opcode[3] ? ODL_OP_TEST_SET : ODL_OP_TEST_CLEAR;
      res.dec.size = ODL_SZ_BYTE;
      res.dec.operands = 2'h2;
    end else begin
      res.dec.cls = opcode[3] ? ODL_CLS_SHORT_CALL : ODL_CLS_SHORT_JUMP;
      res.dec.op = opcode[3] ? ODL_OP_CALL : ODL_OP_JUMP;
    end
  end

endmodule : odl_group_decode

`default_nettype wire

// >>> hw/odl_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - 40..43 decode three-operand word and
// - 44..47 decode three-operand word add
// - 48..4B decode three-operand word subtract
// - 4C..4F decode three-operand unsigned word multiply
// - 50..53 decode three-operand byte and
// - 54..57 decode three-operand byte add
// - 58..5B decode three-operand byte subtract
// - 5C..5F decode three-operand unsigned byte multiply
// - 60..63 two-operand word and, destination reused
// - 64..67 two-operand word add, destination reused
// - low bits: direct, immediate, indirect, indexed
// - 40..5F three operands, 60..6B two
// - 68..6B decode two-operand word subtract
// - reserved opcodes never raise a trap
module odl_decoder import odl_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // opcode bytes from fetch
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  output logic op_ready,
  // decoded instruction to execution control
  output logic dec_valid,
  input wire logic dec_ready,
  output var odl_dec_t dec_info,
  output logic [7:0] dec_opcode,
  output logic dec_trap_req,
  // statistics
  output logic [CNT_W-1:0] reserved_count,
  output logic [CNT_W-1:0] other_page_count
);

  // ----------------------------------------------------------------
  // partial decoders
  // ----------------------------------------------------------------
  odl_dec_if single_res ();
  odl_dec_if group_res ();

  odl_single_decode u_single (
    .opcode (op_byte),
    .res (single_res)
  );

  odl_group_decode u_group (
    .opcode (op_byte),
    .res (group_res)
  );

  // saturating increment, shared by both counters
  function automatic logic [CNT_W-1:0] odl_sat_inc(input logic [CNT_W-1:0] v);
    odl_sat_inc = (&v) ? v : v + CNT_W'(1);
  endfunction : odl_sat_inc

  // ----------------------------------------------------------------
  // merge: above 6B belongs to another decoder page
  // ----------------------------------------------------------------
  odl_dec_t merged;

  always_comb begin
    merged = ODL_DEC_RESET;
    merged.cls = ODL_CLS_OTHER_PAGE;
    if (single_res.hit) begin
      merged = single_res.dec;
    end else if (group_res.hit) begin
      merged = group_res.dec;
    end
  end

  // ----------------------------------------------------------------
  // output stage: one register, refilled in the cycle it drains
  // ----------------------------------------------------------------
  logic valid_q, valid_d;
  odl_dec_t info_q, info_d;
  logic [7:0] opcode_q, opcode_d;
  logic take;

  // fetch stalls only while the held result is not being consumed
  assign op_ready = !valid_q || dec_ready;
  assign take = op_valid && op_ready;

  always_comb begin
    valid_d = valid_q;
    info_d = info_q;
    opcode_d = opcode_q;
    if (take) begin
      valid_d = 1'b1;
      info_d = merged;
      opcode_d = op_byte;
    end else if (dec_ready) begin
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      valid_q <= 1'b0;
      info_q <= ODL_DEC_RESET;
      opcode_q <= ODL_OPCODE_RESET;
    end else begin
      valid_q <= valid_d;
      info_q <= info_d;
      opcode_q <= opcode_d;
    end
  end

  assign dec_valid = valid_q;
  assign dec_info = info_q;
  assign dec_opcode = opcode_q;
  // reserved opcodes run as no-ops; the core never sees a trap from here
  assign dec_trap_req = 1'b0;

  // ----------------------------------------------------------------
  // counters of reserved and off-page opcodes accepted
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] rsv_cnt_q, rsv_cnt_d;
  logic [CNT_W-1:0] oth_cnt_q, oth_cnt_d;

  // counted on acceptance so a stalled byte is not counted twice
  always_comb begin
    rsv_cnt_d = rsv_cnt_q;
    oth_cnt_d = oth_cnt_q;
    if (take && merged.reserved) begin
      rsv_cnt_d = odl_sat_inc(rsv_cnt_q);
    end
    if (take && merged.cls == ODL_CLS_OTHER_PAGE) begin
      oth_cnt_d = odl_sat_inc(oth_cnt_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsv_cnt_q <= '0;
      oth_cnt_q <= '0;
    end else begin
      rsv_cnt_q <= rsv_cnt_d;
      oth_cnt_q <= oth_cnt_d;
    end
  end

  assign reserved_count = rsv_cnt_q;
  assign other_page_count = oth_cnt_q;

endmodule : odl_decoder

`default_nettype wire

// >>> verification/odl_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none

module odl_decoder_checker import odl_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // fetch side
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic op_ready,
  // execution side
  input wire logic dec_valid,
  input wire logic dec_ready,
  input wire odl_dec_t dec_info,
  input wire logic [7:0] dec_opcode,
  input wire logic dec_trap_req,
  // statistics
  input wire logic [CNT_W-1:0] reserved_count,
  input wire logic [CNT_W-1:0] other_page_count
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  // ----
  // handshake steps
  // ----
  sequence s_take;
    op_valid && op_ready;
  endsequence
  sequence s_arith;
    s_take ##0 (op_byte inside {[8'h40:8'h6B]});
  endsequence

  AST_ANSWER: assert property (s_take |=> dec_valid && dec_opcode == $past(op_byte))
    else $error("decoded word late or wrong opcode");
  AST_HOLD: assert property (dec_valid && !dec_ready |=> dec_valid && $stable(dec_info) && $stable(dec_opcode))
    else $error("decoded word changed while stalled");
  AST_READY: assert property (op_ready == (!dec_valid || dec_ready))
    else $error("fetch ready does not follow stall");
  AST_MODE: assert property (s_arith |=> dec_info.cls == ODL_CLS_ARITH &&
    dec_info.mode == odl_mode_t'(dec_opcode[1:0] + 1)) else $error("addressing mode wrong");
  AST_OP: assert property (s_arith |=> dec_info.op == odl_op_t'(ODL_OP_CONJUNCTION + dec_opcode[3:2]))
    else $error("arithmetic group wrong");
  AST_THREE: assert property (s_take ##0 (op_byte inside {[8'h40:8'h5F]}) |=>
    dec_info.operands == 2'h3 && !dec_info.dest_is_src) else $error("three operand form wrong");
  AST_TWO: assert property (s_take ##0 (op_byte inside {[8'h60:8'h6B]}) |=>
    dec_info.operands == 2'h2 && dec_info.dest_is_src) else $error("two operand form wrong");
  AST_BYTE: assert property (s_take ##0 (op_byte[7:4] == 4'h5) |=> dec_info.size == ODL_SZ_BYTE)
    else $error("byte size missing");
  AST_FIELD: assert property (s_take ##0 (op_byte inside {[8'h20:8'h3F]}) |=> dec_info.field == dec_opcode[2:0])
    else $error("operand field wrong");
  AST_RSV: assert property (s_take ##0 (op_byte inside {8'h0B, 8'h10, [8'h1B:8'h1F]}) ##0 !(&reserved_count)
    |=> dec_info.reserved && reserved_count == $past(reserved_count) + 1'b1) else $error("reserved count wrong");
  AST_NO_TRAP: assert property (dec_trap_req == 1'b0)
    else $error("trap raised");
endmodule : odl_decoder_checker

bind odl_decoder odl_decoder_checker #(.CNT_W(CNT_W)) i_odl_decoder_checker (.clk_sys(clk_sys), .srst(srst),
  .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready), .dec_valid(dec_valid), .dec_ready(dec_ready),
  .dec_info(dec_info), .dec_opcode(dec_opcode), .dec_trap_req(dec_trap_req),
  .reserved_count(reserved_count), .other_page_count(other_page_count));

`default_nettype wire

// >>> verification/odl_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none

module odl_fetch_model (
  // clock
  input wire logic clk_sys,
  // fetch handshake
  input wire logic op_ready,
  output logic op_valid,
  output logic [7:0] op_byte
);
  initial begin
    op_valid = 1'b0;
    op_byte = 8'h00;
  end

  // bytes back to back; idle bus shows the inverse so a stale byte never looks valid
  task automatic stream(input logic [7:0] lo, input logic [7:0] hi);
    logic [8:0] b;
    for (b = {1'b0, lo}; b <= {1'b0, hi}; b++) begin
      op_valid <= 1'b1;
      op_byte <= b[7:0];
      do @(posedge clk_sys); while (op_ready !== 1'b1);
    end
    op_valid <= 1'b0;
    op_byte <= ~hi;
  endtask : stream
endmodule : odl_fetch_model

`default_nettype wire

// >>> verification/tb_odl_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module tb_odl_decoder import odl_pkg::*;;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic dec_ready = 1'b1;
  logic slow = 1'b0;
  logic op_valid, op_ready, dec_valid, dec_trap_req;
  logic [7:0] op_byte, dec_opcode;
  odl_dec_t dec_info;
  logic [15:0] reserved_count, other_page_count;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] pend[$];

  // 20 MHz core clock
  always #25 clk_sys = ~clk_sys;

  odl_decoder i_odl_decoder (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid), .op_byte(op_byte),
    .op_ready(op_ready), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_info(dec_info),
    .dec_opcode(dec_opcode), .dec_trap_req(dec_trap_req), .reserved_count(reserved_count),
    .other_page_count(other_page_count));
  odl_fetch_model i_odl_fetch_model (.clk_sys(clk_sys), .op_ready(op_ready), .op_valid(op_valid), .op_byte(op_byte));

  // ----
  // expected decode of one byte
  // ----
  function automatic odl_dec_t exp_dec(input logic [7:0] b);
    odl_dec_t d;
    d = ODL_DEC_RESET;
    if (b > 8'h6B) d.cls = ODL_CLS_OTHER_PAGE;
    else if (b > 8'h3F) d = '{ODL_CLS_ARITH, odl_op_t'(ODL_OP_CONJUNCTION + b[3:2]),
      (b[7:4] == 4'h5) ? ODL_SZ_BYTE : ODL_SZ_WORD, odl_mode_t'(b[1:0] + 1), (b < 8'h60) ? 2'h3 : 2'h2,
      b > 8'h5F, 3'h0, 1'b0};
    else if (b > 8'h1F) d = '{odl_class_t'(ODL_CLS_SHORT_JUMP + b[4:3]), odl_op_t'(ODL_OP_JUMP + b[4:3]),
      b[4] ? ODL_SZ_BYTE : ODL_SZ_NONE, ODL_AM_NONE, b[4] ? 2'h2 : 2'h1, 1'b0, b[2:0], 1'b0};
    else if (b == 8'h0B || b == 8'h10 || b > 8'h1A) d.reserved = 1'b1;
    else begin
      d.cls = ODL_CLS_SINGLE;
      d.operands = 2'h1;
      d.size = b[4] ? ODL_SZ_BYTE : (b[3:2] == 2'h3) ? ODL_SZ_LONG : ODL_SZ_WORD;
      d.op = (b == 8'h00) ? ODL_OP_SKIP : (b[3:2] == 2'h3) ? odl_op_t'(ODL_OP_LOGICAL_RIGHT + b[1:0]) :
        odl_op_t'(ODL_OP_ZERO + b[3:0] - 1);
    end
    return d;
  endfunction : exp_dec

  task automatic chk_dec(input odl_dec_t got, input odl_dec_t exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_dec

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  // score each taken word against the byte offered, in order; slow mode throttles the consumer
  always @(posedge clk_sys) begin
    if (srst) pend.delete();
    else begin
      if (dec_valid === 1'b1 && dec_ready === 1'b1) begin
        chk_val({8'h00, dec_opcode}, {8'h00, pend[0]});
        chk_dec(dec_info, exp_dec(pend[0]));
        void'(pend.pop_front());
      end
      if (op_valid && op_ready === 1'b1) pend.push_back(op_byte);
      if (slow) dec_ready <= ~dec_ready;
    end
  end

  task automatic results();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic reset_dut();
    srst <= 1'b1;
    dec_ready <= 1'b1;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_val(reserved_count, 16'h0000);
  endtask : reset_dut

  task automatic run(input logic [7:0] lo, input logic [7:0] hi);
    i_odl_fetch_model.stream(lo, hi);
    repeat (4) @(posedge clk_sys);
    chk_val(16'(pend.size()), 16'h0000);
  endtask : run

  // consumer stalls: fetch must be refused and the word must stand
  task automatic stall_case();
    dec_ready <= 1'b0;
    fork
      i_odl_fetch_model.stream(8'h4C, 8'h4F);
    join_none
    repeat (4) @(posedge clk_sys);
    chk_val({15'h0000, op_ready}, 16'h0000);
    chk_val({8'h00, dec_opcode}, 16'h004C);
    dec_ready <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk_val(16'(pend.size()), 16'h0000);
  endtask : stall_case

  // main sequence
  initial begin
    reset_dut();
    run(8'h00, 8'h1F);
    run(8'h20, 8'h3F);
    run(8'h40, 8'h43);
    run(8'h44, 8'h47);
    run(8'h48, 8'h4B);
    run(8'h50, 8'h53);
    run(8'h54, 8'h57);
    run(8'h58, 8'h5B);
    run(8'h5C, 8'h5F);
    run(8'h60, 8'h63);
    run(8'h64, 8'h67);
    run(8'h68, 8'h6B);
    stall_case();
    reset_dut();
    slow <= 1'b1;
    run(8'h00, 8'hFF);
    slow <= 1'b0;
    chk_val(reserved_count, 16'h0007);
    chk_val(other_page_count, 16'h0094);
    chk_val({15'h0000, dec_trap_req}, 16'h0000);
    results();
  end

  // watchdog: the whole run needs under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    results();
  end
endmodule : tb_odl_decoder

`default_nettype wire
